/* File: inc/fsc_defines.svh */
// timing counts and field layout shared by both ends of the flash link
// assumes: included by bare name after the package
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH
`define FSC_DW              16
`define FSC_MW              2
`define FSC_AW              12
`define FSC_CMD_TO_CMD      1
`define FSC_SUSPEND_ENTRY   1
`define FSC_SUSPEND_EXIT    1
`define FSC_MASK_TO_INPUT   0
`define FSC_MASK_TO_BLOCK   0
`define FSC_MASK_TO_HIZ     2
`define FSC_WRITE_TO_DATA   0
`define FSC_CFG_TO_ACT      2
`define FSC_PWRUP_US        100
`define FSC_CLK_MHZ         40
`define FSC_PWRUP_CYC       (`FSC_PWRUP_US * `FSC_CLK_MHZ)
`define FSC_LAT_LSB         4
`define FSC_LAT_MSB         6
`define FSC_CFG_RESET       12'h020
`define FSC_FIFO_DEPTH      8
`endif

/* File: inc/fsc_pkg.sv */
// types shared by both ends of the flash link
// assumes: nothing
package fsc_pkg;
  // command code as {row strobe, column strobe, write strobe}, low active
  typedef enum logic [2:0] {
    FSC_CMD_CFG  = 3'h0,
    FSC_CMD_REF  = 3'h1,
    FSC_CMD_PRE  = 3'h2,
    FSC_CMD_ACT  = 3'h3,
    FSC_CMD_WR   = 3'h4,
    FSC_CMD_RD   = 3'h5,
    FSC_CMD_HALT = 3'h6,
    FSC_CMD_NOP  = 3'h7
  } fsc_cmd_t;
endpackage : fsc_pkg

/* File: inc/fsc_if.sv */
// pin bundle between controller and flash device
// assumes: one shared clock; testbench resolves the data bus
`timescale 1ns/100ps
`default_nettype none
interface fsc_if;
  logic                   sel_b;
  logic                   clk_en;
  fsc_pkg::fsc_cmd_t      cmd;
  logic [11:0]            addr;
  logic [1:0]             mask;
  logic [15:0]            dq_ctl;
  logic                   dq_ctl_oe;
  logic [15:0]            dq_dev;
  logic [1:0]             dq_dev_oe;
  logic [15:0]            dq;
  modport dev (input sel_b, clk_en, cmd, addr, mask, dq,
               output dq_dev, dq_dev_oe);
  modport ctl (output sel_b, clk_en, cmd, addr, mask, dq_ctl, dq_ctl_oe,
               input dq);
endinterface : fsc_if
`default_nettype wire

/* File: src/fsc_device.sv */
// flash device end: command decode, suspend, masks, halt, config load
// assumes: pins come from another chip, so they pass two flops first
// Functional notes
// - read or config write accepted back to back
// - clock enable low: suspend one cycle later
// - clock enable high: resume one cycle later
// - write mask applies with no delay
// - masked write byte is not stored
// - read mask floats byte two cycles later; the device floats it three cycles after the sampled mask
// - first write word taken with command
// - controller waits two cycles config to activate
// - after halt drive latency cycles, then float
// - stored config copied in at power-up
// - settings change only by config load
// - deselected cycle is nop, enable ignored
// - controller waits 100us after power-up
// - all latencies counted in whole clocks
`include "fsc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module fsc_device (
  input  wire logic               CLOCK_I,
  input  wire logic               RST_B_I,
  input  wire logic [11:0]        NV_CFG_I,
  fsc_if.dev                      link,
  output logic [11:0]             CFG_O,
  output logic                    SUSPENDED_O,
  output logic                    WR_VALID_O,
  output logic [15:0]             WR_DATA_O,
  output logic [11:0]             WR_ADDR_O
);
  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  localparam int SW = 1 + 1 + 3 + 12 + 2 + 16;
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s1_r <= {1'b1, 1'b1, 3'h7, {SW-5{1'b0}}};
      s2_r <= {1'b1, 1'b1, 3'h7, {SW-5{1'b0}}};
    end else begin
      s1_r <= {link.sel_b, link.clk_en, link.cmd, link.addr, link.mask,
               link.dq};
      s2_r <= s1_r;
    end
  end
  wire        sel_b   = s2_r[SW-1];
  wire        cke     = s2_r[SW-2];
  wire [2:0]  cmd_raw = s2_r[SW-3:SW-5];
  wire [11:0] addr    = s2_r[29:18];
  wire [1:0]  mask    = s2_r[17:16];
  wire [15:0] din     = s2_r[15:0];

  // ----------------------------------------------------------------------
  // suspend and decode
  // ----------------------------------------------------------------------
  logic        susp_r;
  logic        loaded_r;
  logic [11:0] cfg_r;
  logic [1:0]  lat_cnt_r;
  logic [1:0]  lat_cnt_nxt;
  logic        rd_act_r;
  logic [1:0]  rmask_d1_r;
  logic [1:0]  rmask_d2_r;
  logic [15:0] rd_word_r;
  logic [1:0]  oe_r;
  logic [1:0]  oe_nxt;

  // deselect overrides every pin but the mask, enable included
  wire live   = !sel_b && !susp_r;
  wire is_cfg = live && cmd_raw == 3'(fsc_pkg::FSC_CMD_CFG);
  wire is_wr  = live && cmd_raw == 3'(fsc_pkg::FSC_CMD_WR);
  wire is_rd  = live && cmd_raw == 3'(fsc_pkg::FSC_CMD_RD);
  wire is_hlt = live && cmd_raw == 3'(fsc_pkg::FSC_CMD_HALT);
  wire [1:0] lat = cfg_r[`FSC_LAT_MSB-1:`FSC_LAT_LSB];
  wire [1:0] lat_eff = (lat == 2'h0) ? 2'h1 : lat;

  // suspend state follows the sampled enable one edge later
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      susp_r <= 1'b0;
    end else if (!sel_b) begin
      // deselected edges freeze it: enable is ignored then
      susp_r <= !cke;
    end
  end

  // power-up copy of the stored config, caught after reset release
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      loaded_r <= 1'b0;
      cfg_r    <= `FSC_CFG_RESET;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      cfg_r    <= NV_CFG_I;
    end else if (is_cfg) begin
      cfg_r    <= addr;
    end
  end

  // ----------------------------------------------------------------------
  // write path: data and mask taken on the command edge
  // ----------------------------------------------------------------------
  wire [15:0] wr_keep = {{8{!mask[1]}}, {8{!mask[0]}}};
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      WR_VALID_O <= 1'b0;
      WR_DATA_O  <= 16'h0000;
      WR_ADDR_O  <= 12'h000;
    end else begin
      WR_VALID_O <= is_wr && (mask != 2'h3);
      WR_DATA_O  <= din & wr_keep;
      WR_ADDR_O  <= addr;
    end
  end

  // ----------------------------------------------------------------------
  // read path: burst until halt or write; a halt leaves latency cycles of tail
  // ----------------------------------------------------------------------
  always_comb begin
    lat_cnt_nxt = lat_cnt_r;
    if (is_rd) begin
      lat_cnt_nxt = 2'h0;
    end else if (is_hlt && rd_act_r) begin
      lat_cnt_nxt = lat_eff;
    end else if (!rd_act_r && lat_cnt_r != 2'h0) begin
      lat_cnt_nxt = lat_cnt_r - 2'h1;
    end
  end
  wire driving = rd_act_r || lat_cnt_r != 2'h0;
  always_comb begin
    oe_nxt = {2{driving}} & ~rmask_d2_r;
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rd_act_r   <= 1'b0;
      lat_cnt_r  <= 2'h0;
      rmask_d1_r <= 2'h0;
      rmask_d2_r <= 2'h0;
      rd_word_r  <= 16'h0000;
      oe_r       <= 2'h0;
    end else begin
      if (is_rd) begin
        rd_act_r <= 1'b1;
      end else if (is_hlt || is_wr) begin
        rd_act_r <= 1'b0;
      end
      lat_cnt_r  <= lat_cnt_nxt;
      rmask_d1_r <= mask;
      rmask_d2_r <= rmask_d1_r;
      if (is_rd) begin
        rd_word_r <= {4'h0, addr};
      end else if (rd_act_r && !susp_r) begin
        rd_word_r <= rd_word_r + 16'h0001;
      end
      oe_r <= oe_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign link.dq_dev    = rd_word_r;
  assign link.dq_dev_oe = oe_r;
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CFG_O       <= `FSC_CFG_RESET;
      SUSPENDED_O <= 1'b0;
    end else begin
      CFG_O       <= cfg_r;
      SUSPENDED_O <= susp_r;
    end
  end
endmodule : fsc_device
`default_nettype wire

/* File: src/fsc_ctl.sv */
// controller end: buffered user requests turned into link commands
// assumes: shared clock with the device; user side is same clock
`include "fsc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module fsc_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         CLOCK_I,
  input  wire logic         RST_B_I,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  wire full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = wp_r == rp_r;
  wire push  = in_valid_i && !full;
  wire pop   = out_valid_o && out_ready_i;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rp_r[AW-1:0]];
  always_ff @(posedge CLOCK_I) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end
endmodule : fsc_fifo

module fsc_ctl #(
  parameter int PWRUP_CYC = `FSC_PWRUP_CYC
) (
  input  wire logic               CLOCK_I,
  input  wire logic               RST_B_I,
  input  wire logic               REQ_VALID_I,
  output logic                    REQ_READY_O,
  input  wire logic [2:0]         REQ_CMD_I,
  input  wire logic [11:0]        REQ_ADDR_I,
  input  wire logic [1:0]         REQ_MASK_I,
  input  wire logic [15:0]        REQ_DATA_I,
  input  wire logic               REQ_CKE_I,
  output logic                    READY_O,
  fsc_if.ctl                      link
);
  // ----------------------------------------------------------------------
  // request buffer
  // ----------------------------------------------------------------------
  logic        f_valid;
  logic [32:0] f_data;
  logic        take;
  logic        in_rdy;
  fsc_fifo #(.W(33), .D(`FSC_FIFO_DEPTH)) u_fifo (
    .CLOCK_I     (CLOCK_I),
    .RST_B_I     (RST_B_I),
    .in_valid_i  (REQ_VALID_I),
    .in_ready_o  (in_rdy),
    .in_data_i   ({REQ_CMD_I, REQ_ADDR_I, REQ_MASK_I, REQ_DATA_I}),
    .out_valid_o (f_valid),
    .out_ready_i (take),
    .out_data_o  (f_data)
  );
  assign REQ_READY_O = in_rdy;

  // ----------------------------------------------------------------------
  // power-up pause and config-to-activate spacing
  // ----------------------------------------------------------------------
  logic [12:0] pwr_cnt_r;
  logic [1:0]  gap_r;
  wire  pwr_done = pwr_cnt_r == 13'(PWRUP_CYC);
  wire [2:0] f_cmd = f_data[32:30];
  wire is_act = f_cmd == 3'(fsc_pkg::FSC_CMD_ACT);
  wire is_cfg = f_cmd == 3'(fsc_pkg::FSC_CMD_CFG);
  // one command per edge, so reads may follow back to back;
  // activate may land on the second edge after a config load
  assign take = f_valid && pwr_done && !(is_act && gap_r > 2'h1);
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pwr_cnt_r <= 13'h0000;
      gap_r     <= 2'h0;
      READY_O   <= 1'b0;
    end else begin
      if (!pwr_done) begin
        pwr_cnt_r <= pwr_cnt_r + 13'h0001;
      end
      READY_O <= pwr_done;
      if (take && is_cfg) begin
        gap_r <= 2'(`FSC_CFG_TO_ACT);
      end else if (gap_r != 2'h0) begin
        gap_r <= gap_r - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers: write data rides with the command edge
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      link.sel_b     <= 1'b1;
      link.clk_en    <= 1'b1;
      link.cmd       <= fsc_pkg::FSC_CMD_NOP;
      link.addr      <= 12'h000;
      link.mask      <= 2'h0;
      link.dq_ctl    <= 16'h0000;
      link.dq_ctl_oe <= 1'b0;
    end else begin
      link.sel_b     <= !take;
      link.clk_en    <= REQ_CKE_I;
      link.cmd       <= take ? fsc_pkg::fsc_cmd_t'(f_cmd)
                             : fsc_pkg::FSC_CMD_NOP;
      // idle pins parked at zero: the buffer head may be unwritten
      link.addr      <= take ? f_data[29:18] : 12'h000;
      link.mask      <= take ? f_data[17:16] : 2'h0;
      link.dq_ctl    <= take ? f_data[15:0] : 16'h0000;
      link.dq_ctl_oe <= take && f_cmd == 3'(fsc_pkg::FSC_CMD_WR);
    end
  end
endmodule : fsc_ctl
`default_nettype wire

/* File: verif/fsc_link_asserts.sv */
// checker: pin timing between controller and device ends
// assumes: one clock; instanced beside the link bundle
`timescale 1ns/100ps
`default_nettype none
module fsc_link_asserts #(
  parameter int PWRUP_CYC = 4000
) (
  input  wire logic              CLOCK_I,
  input  wire logic              RST_B_I,
  input  wire logic              sel_b,
  input  wire logic              clk_en,
  input  wire fsc_pkg::fsc_cmd_t cmd,
  input  wire logic [1:0]        mask,
  input  wire logic              dq_ctl_oe,
  input  wire logic [1:0]        dq_dev_oe
);
  // ------
  // decode
  // ------
  int   cnt_r;
  logic rd_w;
  logic wr_w;
  logic cfg_w;
  logic act_w;
  logic halt_w;
  logic sus_r;
  assign rd_w   = !sel_b && cmd == fsc_pkg::FSC_CMD_RD;
  assign wr_w   = !sel_b && cmd == fsc_pkg::FSC_CMD_WR;
  assign cfg_w  = !sel_b && cmd == fsc_pkg::FSC_CMD_CFG;
  assign act_w  = !sel_b && cmd == fsc_pkg::FSC_CMD_ACT;
  assign halt_w = !sel_b && cmd == fsc_pkg::FSC_CMD_HALT;
  // saturates so a long run never wraps back into the pause
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) cnt_r <= 0;
    else if (cnt_r < PWRUP_CYC) cnt_r <= cnt_r + 1;
  end
  // pin-level copy of the suspend state: only selected edges move it,
  // which lines it up with what the device decodes
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sus_r <= 1'b0;
    end else if (!sel_b) begin
      sus_r <= !clk_en;
    end
  end
  // ----------
  // properties
  // ----------
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  pwrup_wait_a: assert property (cnt_r < PWRUP_CYC - 1 |-> sel_b)
    else $error("command inside power-up pause");
  wr_data_a: assert property (wr_w |-> dq_ctl_oe)
    else $error("write issued without its data");
  bus_clash_a: assert property (dq_ctl_oe |-> wr_w && !dq_dev_oe)
    else $error("data bus driven outside a write");
  cfg_gap_a: assert property (cfg_w |=> !act_w)
    else $error("activate too soon after config load");
  // device pins pass two flops, so it drives the bus four edges after the pins
  rd_drive_a: assert property ((mask != 2'h3) ##1 (rd_w && !sus_r)
    |-> ##4 |dq_dev_oe)
    else $error("read data not driven");
  rd_start_a: assert property ($rose(|dq_dev_oe) |->
    $past(rd_w, 4) || $past(mask, 6) == 2'h3)
    else $error("data driven without a read");
  mask_hiz_a: assert property (mask[0] |-> ##5 !dq_dev_oe[0])
    else $error("masked read byte still driven");
  halt_end_a: assert property ((halt_w && !sus_r) ##1 (!rd_w) [*7]
    |-> dq_dev_oe == 2'h0)
    else $error("outputs not released after halt");
  rd_c: cover property (rd_w ##1 rd_w ##1 halt_w);
  cfg_c: cover property (cfg_w ##2 act_w);
  sus_c: cover property ($fell(clk_en));
endmodule : fsc_link_asserts
`default_nettype wire

/* File: verif/flash_sdram_cmd_timing_tb.sv */
// testbench: controller and device joined across the link bundle
// assumes: package, bundle and both ends compiled first
`timescale 1ns/100ps
`default_nettype none
module flash_sdram_cmd_timing_tb;
  // -------
  // signals
  // -------
  logic        clk = 1'b0;
  logic        rst_b, valid, ready, cke, rdy_up, susp, wv;
  logic [2:0]  cmd;
  logic [1:0]  mask;
  logic [11:0] addr, nv, cfg, wa;
  logic [15:0] data, wd;
  logic [15:0] junk = 16'h0000;
  logic [45:0] row [4];
  int          miscompares, total_checks, n, n3, n1, h3, h1;
  fsc_if lnk ();
  always #12.5 clk = ~clk;
  // released lines show a value that moves every cycle
  always @(posedge clk) junk <= junk + 16'h3B5D;
  assign lnk.dq = lnk.dq_ctl_oe ? lnk.dq_ctl :
    {lnk.dq_dev_oe[1] ? lnk.dq_dev[15:8] : junk[15:8],
     lnk.dq_dev_oe[0] ? lnk.dq_dev[7:0] : junk[7:0]};
  fsc_ctl #(.PWRUP_CYC(20)) i_fsc_ctl (.CLOCK_I(clk), .RST_B_I(rst_b),
    .REQ_VALID_I(valid), .REQ_READY_O(ready), .REQ_CMD_I(cmd),
    .REQ_ADDR_I(addr), .REQ_MASK_I(mask), .REQ_DATA_I(data),
    .REQ_CKE_I(cke), .READY_O(rdy_up), .link(lnk.ctl));
  fsc_device i_fsc_device (.CLOCK_I(clk), .RST_B_I(rst_b), .NV_CFG_I(nv),
    .link(lnk.dev), .CFG_O(cfg), .SUSPENDED_O(susp), .WR_VALID_O(wv),
    .WR_DATA_O(wd), .WR_ADDR_O(wa));
  fsc_link_asserts #(.PWRUP_CYC(20)) i_fsc_link_asserts (.CLOCK_I(clk),
    .RST_B_I(rst_b), .sel_b(lnk.sel_b), .clk_en(lnk.clk_en), .cmd(lnk.cmd),
    .mask(lnk.mask), .dq_ctl_oe(lnk.dq_ctl_oe), .dq_dev_oe(lnk.dq_dev_oe));
  // -----
  // tasks
  // -----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic tmo(input int k);
    if (k >= 40) begin
      miscompares++;
      close_out();
    end
  endtask : tmo
  // leaves valid high so back-to-back pushes never drop it
  task automatic push(input logic [2:0] c, input logic [11:0] a,
                      input logic [1:0] m, input logic [15:0] d);
    int k;
    cmd = c;
    addr = a;
    mask = m;
    data = d;
    valid = 1'b1;
    for (k = 0; k < 40 && ready !== 1'b1; k++) @(negedge clk);
    tmo(k);
    @(negedge clk);
  endtask : push
  // read, masked read, halt; counts cycles with any byte driven and
  // cycles with only the upper byte driven
  task automatic run_rd(output int cnt, output int half);
    push(fsc_pkg::FSC_CMD_RD, 12'h000, 2'h0, 16'h0000);
    push(fsc_pkg::FSC_CMD_RD, 12'h004, 2'h1, 16'h0000);
    push(fsc_pkg::FSC_CMD_HALT, 12'h000, 2'h0, 16'h0000);
    valid = 1'b0;
    cnt = 0;
    half = 0;
    repeat (40) begin
      @(negedge clk);
      cnt += int'(|lnk.dq_dev_oe);
      half += int'(lnk.dq_dev_oe == 2'h2);
    end
  endtask : run_rd
  // --------
  // sequence
  // --------
  initial begin
    row = '{{12'h001, 2'h0, 16'h1234, 16'h1234},
            {12'h002, 2'h1, 16'h5678, 16'h5600},
            {12'h003, 2'h2, 16'h9ABC, 16'h00BC},
            {12'hFFF, 2'h3, 16'hDEF0, 16'h0000}};
    miscompares = 0;
    total_checks = 0;
    {rst_b, valid, cmd, addr, mask, data} = '0;
    cke = 1'b1;
    nv = 12'h037;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    chk(16'(cfg), 16'h0037);
    chk(16'(rdy_up), 16'h0000);
    foreach (row[i])
      push(fsc_pkg::FSC_CMD_WR, row[i][45:34], row[i][33:32], row[i][31:16]);
    valid = 1'b0;
    foreach (row[i]) begin
      // a fully masked word stores nothing, so no pulse is awaited
      if (row[i][33:32] != 2'h3) begin
        for (n = 0; n < 40 && wv !== 1'b1; n++) @(negedge clk);
        tmo(n);
      end
      chk(16'(wv), 16'(row[i][33:32] != 2'h3));
      chk(wd, row[i][15:0]);
      chk(16'(wa), 16'(row[i][45:34]));
      @(negedge clk);
    end
    chk(16'(rdy_up), 16'h0001);
    // enable only counts on selected edges, so a no-op carries it
    cke = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'(susp), 16'h0000);
    push(fsc_pkg::FSC_CMD_NOP, 12'h000, 2'h0, 16'h0000);
    valid = 1'b0;
    for (n = 0; n < 40 && susp !== 1'b1; n++) @(negedge clk);
    tmo(n);
    cke = 1'b1;
    push(fsc_pkg::FSC_CMD_NOP, 12'h000, 2'h0, 16'h0000);
    valid = 1'b0;
    for (n = 0; n < 40 && susp !== 1'b0; n++) @(negedge clk);
    tmo(n);
    run_rd(n3, h3);
    push(fsc_pkg::FSC_CMD_CFG, 12'h017, 2'h0, 16'h0000);
    push(fsc_pkg::FSC_CMD_ACT, 12'h000, 2'h0, 16'h0000);
    valid = 1'b0;
    for (n = 0; n < 40 && cfg !== 12'h017; n++) @(negedge clk);
    tmo(n);
    chk(16'(cfg), 16'h0017);
    run_rd(n1, h1);
    chk(16'(n3 - n1), 16'h0002);
    chk(16'(n1), 16'h0003);
    chk(16'(h3), 16'h0001);
    chk(16'(h1), 16'h0001);
    close_out();
  end
endmodule : flash_sdram_cmd_timing_tb
`default_nettype wire
